/* File: rtl/fbmc_pkg.sv */
// How it works
// - Erase, program and lock changes need a two-write command sequence.
// - Host reads with select and gate low, strobe high, reset high.
// - Host holds reset/power-down low for the minimum pulse width.
// - Data is not valid until the wake-up interval has passed.
// - Host waits the recovery interval after abort before writing.
// - Flash reset pin follows the processor's own reset.
package fbmc_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PS = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int unsigned PD_PULSE_NS = 100;
  localparam int unsigned WAKE_VALID_NS = 400;
  localparam int unsigned WAKE_WRITE_NS = 1000;
  localparam int unsigned SETUP_NS = 100;
  localparam int unsigned STROBE_NS = 100;
  localparam int unsigned ACCESS_NS = 100;
  // Least times round up to whole cycles
  localparam int unsigned PD_PULSE_CYC = (PD_PULSE_NS * 1000 + CLK_PS - 1)
    / CLK_PS;
  localparam int unsigned WAKE_VALID_CYC = (WAKE_VALID_NS * 1000 + CLK_PS - 1)
    / CLK_PS;
  localparam int unsigned WAKE_WRITE_CYC = (WAKE_WRITE_NS * 1000 + CLK_PS - 1)
    / CLK_PS;
  localparam int unsigned SETUP_CYC = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned STROBE_CYC = (STROBE_NS * 1000 + CLK_PS - 1)
    / CLK_PS;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PS - 1)
    / CLK_PS;
  localparam int unsigned SYNC_CYC = 2; // Depth of the read bus synchroniser
  localparam int CNT_W = 8;

  // Bus widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;

  // Status value expected after power-down exit
  localparam logic [7:0] STATUS_AFTER_PD = 8'h80;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

  // Host request kinds
  typedef enum logic [1:0] {
    FBMC_REQ_READ,
    FBMC_REQ_WRITE,
    FBMC_REQ_POWERDOWN
  } fbmc_req_t;

endpackage

/* File: rtl/fbmc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Loadable down-counter; done is high when it reaches zero
module fbmc_timer #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;

  // Counts down once per cycle, holds at zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0);
endmodule
`default_nettype wire

/* File: rtl/fbmc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fbmc_host (
  input wire logic mclk,
  input wire logic nrst,
  // User request side
  input wire logic req_valid,
  input wire fbmc_pkg::fbmc_req_t req_kind,
  input wire logic [fbmc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fbmc_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [fbmc_pkg::DATA_W-1:0] rsp_rdata,
  output logic flash_busy,
  output logic status_expected,
  // Flash pins
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic write_strobe_n,
  output logic reset_powerdown_n,
  output logic [fbmc_pkg::ADDR_W-1:0] addr,
  input wire logic [fbmc_pkg::DATA_W-1:0] data_lines_in,
  output logic [fbmc_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic ready_busy_n
);
  import fbmc_pkg::*;

  typedef enum logic [3:0] {
    ST_RESET, ST_WAKE, ST_IDLE, ST_RD_ACCESS, ST_RD_DONE,
    ST_WR_SETUP, ST_WR_STROBE, ST_WR_HOLD, ST_PD_LOW
  } fbmc_state_t;

  fbmc_state_t state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic rsp_q, rsp_d;
  logic oe_q, oe_d;
  logic cs_n_q, cs_n_d;
  logic og_n_q, og_n_d;
  logic ws_n_q, ws_n_d;
  logic rstpd_n_q, rstpd_n_d;
  logic stat_q, stat_d;
  logic rb_s1_q, rb_s2_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic t_load;
  logic [CNT_W-1:0] t_value;
  logic t_done;
  logic w_load;
  logic w_done;

  //////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  // Two flops for the ready/busy level and the read bus
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
      dq_s1_q <= data_lines_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interval timers

  // Phase timer for pulse widths and access
  fbmc_timer #(.W(CNT_W)) u_phase (
    .mclk(mclk),
    .nrst(nrst),
    .load(t_load),
    .value(t_value),
    .done(t_done)
  );

  // Recovery timer before the next write after wake
  fbmc_timer #(.W(CNT_W)) u_wake_wr (
    .mclk(mclk),
    .nrst(nrst),
    .load(w_load),
    .value(CNT_W'(WAKE_WRITE_CYC)),
    .done(w_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  wire is_write = req_kind == FBMC_REQ_WRITE;
  // Writes wait for recovery; reads and power-down do not
  wire can_take = (state_q == ST_IDLE) && (!is_write || w_done);
  wire take = req_valid && can_take;

  // Next-state and pin sequencing
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    oe_d = oe_q;
    cs_n_d = cs_n_q;
    og_n_d = og_n_q;
    ws_n_d = ws_n_q;
    rstpd_n_d = rstpd_n_q;
    stat_d = stat_q;
    t_load = 1'b0;
    t_value = '0;
    w_load = 1'b0;
    unique case (state_q)
      // Reset pin held low from system reset
      ST_RESET: begin
        if (t_done) begin
          rstpd_n_d = 1'b1;
          t_load = 1'b1;
          t_value = CNT_W'(WAKE_VALID_CYC);
          w_load = 1'b1;
          state_d = ST_WAKE;
        end
      end
      // No read before wake-up time
      ST_WAKE: begin
        if (t_done) begin
          stat_d = 1'b0; // Device back in read array
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          addr_d = req_addr;
          wdata_d = req_wdata;
          unique case (req_kind)
            FBMC_REQ_READ: begin
              cs_n_d = 1'b0;
              og_n_d = 1'b0;
              t_load = 1'b1;
              t_value = CNT_W'(ACCESS_CYC + SYNC_CYC);
              state_d = ST_RD_ACCESS;
            end
            // One request is one bus write; a pair is two requests
            FBMC_REQ_WRITE: begin
              cs_n_d = 1'b0;
              og_n_d = 1'b1; // Gate high so device never drives
              t_load = 1'b1;
              t_value = CNT_W'(SETUP_CYC);
              state_d = ST_WR_SETUP;
            end
            default: begin
              rstpd_n_d = 1'b0; // Deep power-down, aborts any op
              t_load = 1'b1;
              t_value = CNT_W'(PD_PULSE_CYC);
              state_d = ST_PD_LOW;
            end
          endcase
        end
      end
      // Extra two cycles cover the input synchroniser
      ST_RD_ACCESS: begin
        if (t_done) begin
          rdata_d = dq_s2_q;
          state_d = ST_RD_DONE;
        end
      end
      ST_RD_DONE: begin
        cs_n_d = 1'b1;
        og_n_d = 1'b1;
        rsp_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_WR_SETUP: begin
        if (t_done) begin
          oe_d = 1'b1;
          ws_n_d = 1'b0;
          t_load = 1'b1;
          t_value = CNT_W'(STROBE_CYC);
          state_d = ST_WR_STROBE;
        end
      end
      // Rising strobe edge latches address and data
      ST_WR_STROBE: begin
        if (t_done) begin
          ws_n_d = 1'b1;
          state_d = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        oe_d = 1'b0;
        cs_n_d = 1'b1;
        rsp_d = 1'b1;
        // Track read mode: array command clears status mode
        stat_d = wdata_q != CMD_READ_ARRAY;
        state_d = ST_IDLE;
      end
      // Power-down pulse width
      ST_PD_LOW: begin
        if (t_done) begin
          rstpd_n_d = 1'b1;
          t_load = 1'b1;
          t_value = CNT_W'(WAKE_VALID_CYC);
          w_load = 1'b1;
          state_d = ST_WAKE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Sequencer and pin registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RESET;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rsp_q <= 1'b0;
      oe_q <= 1'b0;
      cs_n_q <= 1'b1;
      og_n_q <= 1'b1;
      ws_n_q <= 1'b1;
      rstpd_n_q <= 1'b0;
      stat_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      oe_q <= oe_d;
      cs_n_q <= cs_n_d;
      og_n_q <= og_n_d;
      ws_n_q <= ws_n_d;
      rstpd_n_q <= rstpd_n_d;
      stat_q <= stat_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // Timers reset to zero, so the reset pin rises one edge after nrst;
  // its low time is the nrst low time plus one cycle
  assign req_ready = can_take;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign flash_busy = !rb_s2_q;
  assign status_expected = stat_q;
  assign chip_sel_n = cs_n_q;
  assign out_gate_n = og_n_q;
  assign write_strobe_n = ws_n_q;
  assign reset_powerdown_n = rstpd_n_q;
  assign addr = addr_q;
  assign data_lines_out = wdata_q;
  assign data_lines_oe = oe_q;
endmodule
`default_nettype wire

/* File: tb/fbmc_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fbmc_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_strobe_n,
  input wire logic reset_powerdown_n,
  input wire logic [fbmc_pkg::ADDR_W-1:0] addr,
  input wire logic data_lines_oe
);
  import fbmc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles low and cycles since wake; up_q saturates so it never wraps
  logic [7:0] low_q;
  logic [7:0] up_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      low_q <= '0;
      up_q <= '0;
    end else if (!reset_powerdown_n) begin
      low_q <= low_q + 8'h01;
      up_q <= '0;
    end else begin
      low_q <= '0;
      up_q <= (up_q == 8'hff) ? up_q : up_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_read_pins;
    !out_gate_n |-> !chip_sel_n && write_strobe_n && reset_powerdown_n;
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("read pins");
  property p_no_clash;
    data_lines_oe |-> out_gate_n;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus clash");
  property p_pd_width;
    $rose(reset_powerdown_n) |-> low_q >= PD_PULSE_CYC;
  endproperty
  a_pd_width: assert property (p_pd_width) else $error("short pd");
  property p_wake_read;
    !out_gate_n |-> up_q >= WAKE_VALID_CYC;
  endproperty
  a_wake_read: assert property (p_wake_read)
    else $error("early read");
  property p_wake_write;
    !write_strobe_n |-> up_q >= WAKE_WRITE_CYC && out_gate_n;
  endproperty
  a_wake_write: assert property (p_wake_write)
    else $error("early wr");
  property p_latch;
    $rose(write_strobe_n) |-> data_lines_oe && !chip_sel_n && $stable(addr);
  endproperty
  a_latch: assert property (p_latch) else $error("bad latch");
endmodule
bind fbmc_host fbmc_sva i_sva (.mclk, .nrst, .chip_sel_n, .out_gate_n,
  .write_strobe_n, .reset_powerdown_n, .addr, .data_lines_oe);
`default_nettype wire

/* File: tb/fbmc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fbmc_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h00, // Arbitrary value
  parameter int WAKE_NS = 400,
  parameter int PROG_NS = 1500,
  parameter logic [15:0] LOCKED = 16'h0080 // Word 7 is locked
) (
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_strobe_n,
  input wire logic reset_powerdown_n,
  input wire logic vpp_ok,
  input wire logic [20:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic ready_busy_n
);
  logic [7:0] mem [16];
  logic [1:0] mode;
  logic setup, awake;
  logic [7:0] sr, q;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {mode, setup, awake, sr, ready_busy_n} = {4'h0, 8'h80, 1'b1};
  end
  // Latch on strobe rise; writes blocked while down or busy
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && reset_powerdown_n && ready_busy_n) begin
      if (setup) begin // Only the pair alters the array
        // Low supply or a locked word refuses the change
        if (vpp_ok && !LOCKED[addr[3:0]]) mem[addr[3:0]] = din;
        {setup, mode, sr, ready_busy_n} = {3'h1, 8'h00, 1'b0};
        ready_busy_n <= #PROG_NS 1'b1; // Runs on if deselected
        sr <= #PROG_NS 8'h80;
      end else begin // Last read command picks the source
        setup = din == 8'h40 || din == 8'h10;
        if (din == 8'hff) mode = 2'h0;
        else if (din == 8'h70 || setup) mode = 2'h1;
        else if (din == 8'h90) mode = 2'h2;
      end
    end
  end
  // Wake into read array with status 80
  always @(reset_powerdown_n) begin
    awake = 1'b0;
    if (reset_powerdown_n) begin
      {mode, setup, sr} = {3'h0, 8'h80};
      #WAKE_NS awake = 1'b1;
    end
  end
  // Not driving shows garbage, never a held value
  // Status and codes read whatever the supply level
  assign q = mode == 2'h0 ? mem[addr[3:0]] : mode == 2'h1 ? sr : ID_CODE;
  assign dout = (!chip_sel_n && !out_gate_n && write_strobe_n && awake) ?
    q : ~q;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fbmc_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary value
  logic mclk, nrst, req_valid, req_ready, rsp_valid, flash_busy;
  logic status_expected, chip_sel_n, out_gate_n, write_strobe_n;
  logic reset_powerdown_n, data_lines_oe, ready_busy_n, vpp_ok;
  fbmc_req_t req_kind;
  logic [ADDR_W-1:0] req_addr, addr;
  logic [7:0] req_wdata, rsp_rdata, data_lines_in, data_lines_out, flash_q;
  int n_errors, n_compared, cyc;
  // Bus level from whichever side enables
  assign data_lines_in = data_lines_oe ? data_lines_out : flash_q;
  fbmc_host i_dut (.mclk, .nrst, .req_valid, .req_kind, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .flash_busy,
    .status_expected, .chip_sel_n, .out_gate_n, .write_strobe_n,
    .reset_powerdown_n, .addr, .data_lines_in, .data_lines_out,
    .data_lines_oe, .ready_busy_n);
  fbmc_flash_model #(.ID_CODE(ID)) i_flash (.chip_sel_n, .out_gate_n,
    .write_strobe_n, .reset_powerdown_n, .addr, .din(data_lines_in),
    .dout(flash_q), .ready_busy_n, .vpp_ok);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Hold request until taken; trailing edge keeps drives apart
  task automatic op(input fbmc_req_t k, input logic [20:0] a,
                    input logic [7:0] d);
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    do @(negedge mclk); while (req_ready !== 1'b1);
    @(posedge mclk);
    req_valid <= 1'b0;
    if (k != FBMC_REQ_POWERDOWN) do @(negedge mclk); while (rsp_valid !== 1);
    @(posedge mclk);
  endtask
  task automatic wr(input logic [20:0] a, input logic [7:0] d);
    op(FBMC_REQ_WRITE, a, d);
  endtask
  task automatic rd(input logic [20:0] a, input logic [7:0] exp);
    op(FBMC_REQ_READ, a, 8'h00);
    chk("read byte", rsp_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    rd(21'h5, 8'hff);
    wr(21'h0, 8'h70);
    chk("status flag", {7'h0, status_expected}, 8'h01);
    rd(21'h0, 8'h80);
    wr(21'h0, 8'h90);
    rd(21'h0, ID);
    wr(21'h0, 8'hff);
    chk("status flag", {7'h0, status_expected}, 8'h00);
  endtask
  // Command pair, then wait out the busy period
  task automatic prog(input logic [20:0] a, input logic [7:0] d);
    wr(a, 8'h40);
    wr(a, d);
    do @(negedge mclk); while (flash_busy !== 1'b1);
    do @(negedge mclk); while (flash_busy !== 1'b0);
    @(posedge mclk);
  endtask
  task automatic t_program();
    prog(21'h3, 8'ha5);
    rd(21'h0, 8'h80);
    wr(21'h0, 8'hff);
    rd(21'h3, 8'ha5);
    rd(21'h4, 8'hff);
  endtask
  // A lone data write must leave the array alone
  task automatic t_stray();
    wr(21'h6, 8'h5a);
    wr(21'h0, 8'hff);
    rd(21'h6, 8'hff);
  endtask
  task automatic t_powerdown();
    wr(21'h0, 8'h70);
    op(FBMC_REQ_POWERDOWN, 21'h0, 8'h00);
    rd(21'h3, 8'ha5);
    wr(21'h0, 8'h70);
    rd(21'h0, 8'h80);
  endtask
  // Low supply or a locked word must leave the array alone
  task automatic t_protect();
    vpp_ok <= 1'b0;
    prog(21'h4, 8'h11);
    rd(21'h0, 8'h80);
    vpp_ok <= 1'b1;
    prog(21'h7, 8'h22);
    wr(21'h0, 8'hff);
    rd(21'h4, 8'hff);
    rd(21'h7, 8'hff);
  endtask
  // A system reset mid-run also puts the flash back in read array
  task automatic t_sysreset();
    wr(21'h0, 8'h70);
    nrst <= 1'b0;
    @(posedge mclk);
    chk("reset pin", {7'h0, reset_powerdown_n}, 8'h00);
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(21'h3, 8'ha5);
  endtask
  initial begin
    {nrst, req_valid, req_addr, req_wdata} = '0;
    req_kind = FBMC_REQ_READ;
    vpp_ok = 1'b1;
    {n_errors, n_compared, cyc} = '0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_modes();
    t_program();
    t_stray();
    t_powerdown();
    t_protect();
    t_sysreset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
